// ---- change_notify_defines.svh ----
// Constants for the input change notifier
`ifndef CHANGE_NOTIFY_DEFINES_SVH
`define CHANGE_NOTIFY_DEFINES_SVH

`define CN_PIN_COUNT     16
`define CN_ENABLE_RESET  16'h0000
`define CN_PULLUP_RESET  16'h0000
`define CN_MIN_HOLD_TCY  2

`endif

// ---- change_notify_pkg.sv ----
// Types shared by the input change notifier
`include "change_notify_defines.svh"
`default_nettype none
package change_notify_pkg;
    typedef logic [`CN_PIN_COUNT-1:0] pin_vec_type;

    typedef struct packed {
        pin_vec_type irq_enable;
        pin_vec_type pullup_enable;
    } cn_config_type;
endpackage
`default_nettype wire

// ---- input_change_notifier.sv ----
// Input change notification: sampling, compare, sticky flag, sleep wake path
`include "change_notify_defines.svh"
`default_nettype none
module input_change_notifier
(
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    // Monitored pins, raw from the pads
    input  wire change_notify_pkg::pin_vec_type change_monitored_pin,
    // Per-pin enables written by the core
    input  wire change_notify_pkg::cn_config_type cfg,
    // Core side: sleep indication and flag clear
    input  wire logic                        sleep_mode,
    input  wire logic                        flag_clear,
    // Results
    output logic                             change_irq,
    output logic                             sleep_wake,
    output change_notify_pkg::pin_vec_type   pullup_on
);
    import change_notify_pkg::*;

    // ==========================================================
    // Input synchroniser
    pin_vec_type sync_meta;
    pin_vec_type sync_pin;
    pin_vec_type last_sample;
    pin_vec_type sleep_ref;
    logic        primed;
    logic [1:0]  prime_fill;
    logic        pin_state_change;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_meta <= '0;
            sync_pin  <= '0;
        end
        else
        begin
            sync_meta <= change_monitored_pin;
            sync_pin  <= sync_meta;
        end
    end

    // ==========================================================
    // Change compare
    // Two synchroniser stages mean a level held for two cycles is always seen
    // A pulse shorter than that may slip between two samples and be lost;
    // this is the price of sampling the pads on the instruction clock.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            last_sample <= '0;
        else
            last_sample <= sync_pin;
    end

    // The compare stays blind until both synchroniser stages and the last
    // sample hold real pad levels. Without this, a pin that idles high (a
    // button with its pull-up on) would look like a change after reset.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prime_fill <= 2'h0;
            primed     <= 1'b0;
        end
        else
        begin
            prime_fill <= {prime_fill[0], 1'b1};
            primed     <= prime_fill[1];
        end
    end

    // Per-pin enable gates each compare bit; first three cycles after reset are ignored
    assign pin_state_change = primed &&
        (|((sync_pin ^ last_sample) & cfg.irq_enable));

    // ==========================================================
    // Sticky flag: a new change wins over a clear in the same cycle
    // Losing the set would drop a button press that lands while software
    // is still acknowledging the previous one.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            change_irq <= 1'b0;
        else if (pin_state_change)
            change_irq <= 1'b1;
        else if (flag_clear)
            change_irq <= 1'b0;
    end

    // ==========================================================
    // Sleep path: the pad levels are compared against a snapshot taken while
    // running, with no clock involved, so a change wakes the core even when
    // mclk is stopped. The snapshot freezes once sleep_mode is high.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            sleep_ref <= '0;
        else if (!sleep_mode)
            sleep_ref <= sync_pin;
    end

    // The raw pads are read here on purpose: with the clock stopped the
    // synchroniser cannot move. The wake line is therefore asynchronous and
    // the core must resynchronise it before using it as a clocked signal.
    // A pin that changes and returns while asleep drops the wake line again.
    assign sleep_wake = sleep_mode &&
        (|((change_monitored_pin ^ sleep_ref) & cfg.irq_enable));

    // ==========================================================
    // Pull-up controls; turning them off on outputs is left to software
    assign pullup_on = cfg.pullup_enable;

    // ==========================================================
    // Checks: capture path
    logic past_valid;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            past_valid <= 1'b0;
        else
            past_valid <= 1'b1;
    end

    sync_chain_a: assert property (@(posedge mclk) disable iff (!rst_n)
        past_valid |-> sync_pin == $past(sync_meta))
        else $error("synchroniser stage skipped");

    sample_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        past_valid |-> last_sample == $past(sync_pin))
        else $error("last sample not updated");

    // ==========================================================
    // Checks: flag
    flag_sets_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pin_state_change |=> change_irq)
        else $error("change did not set the flag");

    flag_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
        change_irq && !flag_clear |=> change_irq)
        else $error("flag dropped without a clear");

    flag_clears_a: assert property (@(posedge mclk) disable iff (!rst_n)
        flag_clear && !pin_state_change |=> !change_irq)
        else $error("flag did not clear");

    clear_race_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pin_state_change && flag_clear |=> change_irq)
        else $error("clear beat a new change");

    quiet_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !change_irq && !pin_state_change |=> !change_irq)
        else $error("flag rose without a change");

    masked_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg.irq_enable == '0 |-> !pin_state_change)
        else $error("change seen on disabled pins");

    held_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
        past_valid && primed && ($past(sync_pin) != sync_pin)
        && (($past(sync_pin) ^ sync_pin) & cfg.irq_enable) != '0
        |=> change_irq)
        else $error("enabled edge missed");

    pin_to_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
        primed && ((change_monitored_pin ^ sync_pin) & cfg.irq_enable) != '0
        && $stable(change_monitored_pin) && $stable(cfg.irq_enable)
        |=> ##[1:2] change_irq)
        else $error("stable change not flagged");

    // ==========================================================
    // Checks: sleep path and pull-ups
    sleep_wake_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !sleep_mode |-> !sleep_wake)
        else $error("wake outside sleep");

    snapshot_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        past_valid && $past(sleep_mode) |-> sleep_ref == $past(sleep_ref))
        else $error("snapshot moved during sleep");

    wake_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        sleep_mode && ((change_monitored_pin ^ sleep_ref) & cfg.irq_enable) != '0
        |-> sleep_wake)
        else $error("sleep change did not wake");

    pullup_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pullup_on == cfg.pullup_enable)
        else $error("pull-up control mismatch");

    // ==========================================================
    // Coverage of the main scenarios
    flag_set_c:    cover property (@(posedge mclk) disable iff (!rst_n) $rose(change_irq));
    masked_c:      cover property (@(posedge mclk) disable iff (!rst_n)
        primed && (sync_pin ^ last_sample) != '0 && !pin_state_change);
    sleep_flag_c:  cover property (@(posedge mclk) disable iff (!rst_n)
        sleep_mode && change_irq);
    clear_race_c:  cover property (@(posedge mclk) disable iff (!rst_n)
        pin_state_change && flag_clear);
    sleep_wake_c:  cover property (@(posedge mclk) disable iff (!rst_n) $rose(sleep_wake));
endmodule
`default_nettype wire

// ---- input_change_notifier_bench.sv ----
// Self-checking bench for the input change notifier
`default_nettype none
module input_change_notifier_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import change_notify_pkg::*;
    logic          mclk = 1'b0;
    logic          clk_run = 1'b1;
    logic          rst_n = 1'b0;
    logic          sleep_mode = 1'b0;
    logic          flag_clear = 1'b0;
    pin_vec_type   drive_val = '0;
    pin_vec_type   drive_en = '1;
    cn_config_type cfg = '0;
    pin_vec_type   pads;
    pin_vec_type   pullup_on;
    logic          change_irq;
    logic          sleep_wake;
    int            bad_count = 0;
    int            total_checks = 0;
    // Clock can be stopped to model sleep with no instruction clock
    always #50 if (clk_run) mclk = ~mclk;
    pin_source far_side (.mclk(mclk), .drive_val(drive_val), .drive_en(drive_en),
        .pullup_on(pullup_on), .pad(pads));
    input_change_notifier uut (.mclk(mclk), .rst_n(rst_n), .change_monitored_pin(pads),
        .cfg(cfg), .sleep_mode(sleep_mode), .flag_clear(flag_clear),
        .change_irq(change_irq), .sleep_wake(sleep_wake), .pullup_on(pullup_on));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #10;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 6 && change_irq !== 1'b1; i++) tick(1);
        check(change_irq, 1'b1);
        if (change_irq !== 1'b1)
            give_verdict;
    endtask
    task automatic clear_flag;
        flag_clear = 1'b1;
        tick(1);
        flag_clear = 1'b0;
        check(change_irq, 1'b0);
    endtask
    task automatic t_change;
        cfg.irq_enable = 16'h8008;
        drive_val[3] = 1'b1;
        wait_irq;
        tick(4);
        check(change_irq, 1'b1);
        clear_flag;
        $display("change test done");
    endtask
    task automatic t_masked;
        drive_val[5] = 1'b1;
        tick(6);
        check(change_irq, 1'b0);
        drive_val[15] = 1'b1;
        wait_irq;
        clear_flag;
        $display("masked test done");
    endtask
    task automatic t_pullup;
        drive_en = 16'hff00;
        cfg.pullup_enable = 16'h00ff;
        #1;
        check(pullup_on, 16'h00ff);
        check(pads[7:0], 8'hff);
        $display("pull-up test done");
    endtask
    task automatic t_sleep;
        sleep_mode = 1'b1;
        tick(2);
        check(sleep_wake, 1'b0);
        clk_run = 1'b0;
        #300;
        drive_en = '1;
        drive_val[15] = 1'b0;
        #1;
        check(sleep_wake, 1'b1);
        clk_run = 1'b1;
        tick(1);
        $display("sleep test done");
    endtask
    task automatic t_reset;
        sleep_mode = 1'b0;
        rst_n = 1'b0;
        tick(2);
        check(change_irq, 1'b0);
        rst_n = 1'b1;
        tick(8);
        check(change_irq, 1'b0);
        $display("reset test done");
    endtask
    initial
    begin
        tick(5);
        rst_n = 1'b1;
        tick(3);
        t_change;
        t_masked;
        t_pullup;
        t_sleep;
        t_reset;
        give_verdict;
    end
endmodule
`default_nettype wire

// ---- pin_source.sv ----
// Pad model for the monitored pins
`default_nettype none
module pin_source
(
    // Clock
    input  wire logic                         mclk,
    // Bench drive
    input  wire change_notify_pkg::pin_vec_type drive_val,
    input  wire change_notify_pkg::pin_vec_type drive_en,
    input  wire change_notify_pkg::pin_vec_type pullup_on,
    // Pads
    output var  change_notify_pkg::pin_vec_type pad
);
    timeunit 1ns;
    timeprecision 1ns;
    import change_notify_pkg::*;
    pin_vec_type float_val = '0;
    // A floating pad with no pull-up must not look stable
    always @(posedge mclk) float_val <= ~float_val;
    assign pad = (drive_en & drive_val) | (~drive_en & (pullup_on | float_val));
endmodule
`default_nettype wire
